// file: include/prfm_consts.vh
// constants for the pid regulator and feedback monitor
`ifndef PRFM_CONSTS_VH
`define PRFM_CONSTS_VH

`define REG_MODE      5'h00
`define REG_PGAIN     5'h01
`define REG_ITIME     5'h02
`define REG_ILIM      5'h03
`define REG_DTIME     5'h04
`define REG_OLIM      5'h05
`define REG_BIAS      5'h06
`define REG_FTIME     5'h07
`define REG_POL       5'h08
`define REG_OGAIN     5'h09
`define REG_REV       5'h0A
`define REG_SUPV      5'h0B
`define REG_LOWLVL    5'h0C
`define REG_LOWTIME   5'h0D
`define REG_HIGHLVL   5'h0E
`define REG_HIGHTIME  5'h0F
`define REG_TARGET    5'h10
`define REG_STATUS    5'h11
`define REG_PIDOUT    5'h12

`define RST_MODE      3'h0
`define RST_PGAIN     16'h0064
`define RST_ITIME     16'h0064
`define RST_ILIM      16'h03E8
`define RST_DTIME     16'h0000
`define RST_OLIM      16'h03E8
`define RST_BIAS      16'h0000
`define RST_FTIME     16'h0000
`define RST_OGAIN     16'h0064
`define RST_SUPV      3'h0
`define RST_LOWLVL    16'h0000
`define RST_LOWTIME   16'h000A
`define RST_HIGHLVL   16'h0064
`define RST_HIGHTIME  16'h000A
`define RST_TARGET    16'h0000

`define RMODE_PID1    3'h1
`define RMODE_PID2    3'h2
`define RMODE_CMD1    3'h3
`define RMODE_CMD2    3'h4

`define SUP_IND       3'h0
`define SUP_ALARM     3'h1
`define SUP_FAULT     3'h2
`define SUP_IND_D     3'h3
`define SUP_ALARM_D   3'h4
`define SUP_FAULT_D   3'h5
`define SUP_IND_RUN   3'h6
`define SUP_IND_ANY   3'h7

`define CLK_PERIOD_NS   40
`define LOOP_PERIOD_US  1000
`define NS_PER_US       1000
`define DET_UNIT_TICKS  16'h0064
`define TIME_UNIT_TICKS 32'h0000000A
`define GAIN_DIV        32'h00000064
`define LVL_SCALE       32'h0000000A
`define FULL_SCALE      32'h000003E8
`define FULL_SCALE_16   16'h03E8
`define FILT_SHIFT      10
`define CNT_MAX         16'hFFFF

`define ST_LOW        0
`define ST_HIGH       1
`define ST_ALARM      2
`define ST_FAULT      3
`define ST_STOP       4
`define ST_REV        5
`define ST_PIDON      6
`define ST_ACT        7

`endif

// file: verilog/prfm_regulator.v
// pid regulator stage with feedback low/high supervision
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "prfm_consts.vh"
module prfm_regulator #(
    parameter [15:0] TICK_CYCLES = `LOOP_PERIOD_US * `NS_PER_US / `CLK_PERIOD_NS
) (
    input  wire        clk,
    input  wire        reset,
    input  wire [4:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr_en,
    input  wire        rd_en,
    output reg  [15:0] rdata_q,
    input  wire [15:0] feedback,
    input  wire [15:0] freq_command,
    input  wire        drive_running,
    input  wire        pid_disable_input,
    input  wire        fault_reset,
    output reg  [15:0] freq_out_q,
    output reg         reverse_q,
    output reg         stop_q,
    output reg         fb_low_out_q,
    output reg         fb_high_out_q,
    output reg         alarm_out_q,
    output reg         fault_out_q
);

    reg  [2:0]         mode_q;
    reg  [15:0]        pgain_q;
    reg  [15:0]        itime_q;
    reg  [15:0]        ilim_q;
    reg  [15:0]        dtime_q;
    reg  [15:0]        olim_q;
    reg  [15:0]        bias_q;
    reg  [15:0]        ftime_q;
    reg                pol_q;
    reg  [15:0]        ogain_q;
    reg                rev_q;
    reg  [2:0]         supv_q;
    reg  [15:0]        lowlvl_q;
    reg  [15:0]        lowtime_q;
    reg  [15:0]        highlvl_q;
    reg  [15:0]        hightime_q;
    reg  [15:0]        target_q;

    reg  [15:0]        tick_cnt_q;
    reg                tick_q;
    reg  signed [31:0] iacc_q;
    reg  signed [31:0] iterm_q;
    reg  signed [31:0] dprev_q;
    reg  signed [31:0] fy_q;
    reg  signed [31:0] pid_q;
    reg                negstop_q;

    wire signed [31:0] fb_w;
    wire [15:0]        det_lvl  [0:1];
    wire [15:0]        det_time [0:1];
    wire [1:0]         det;
    wire               pid_mode_on;
    wire               pid_on;
    wire               trim_mode;
    reg                sup_act;

    reg  signed [31:0] err;
    reg  signed [31:0] dsrc;
    reg  signed [31:0] p_term;
    reg  signed [31:0] d_term;
    reg  signed [31:0] i_div;
    reg  signed [31:0] i_next;
    reg  signed [31:0] i_quot;
    reg                i_hold;
    reg  signed [31:0] sum;
    reg  signed [31:0] lim_v;
    reg  signed [31:0] f_div;
    reg  signed [31:0] f_next;
    reg  signed [31:0] biased;
    reg  signed [31:0] gained;
    reg  signed [31:0] pid_v;
    reg                negstop_v;
    reg  signed [31:0] out_v;
    reg  [7:0]         status_v;

    // symmetric limit of a signed value to +/- lim
    function signed [31:0] clamp_sym;
        input signed [31:0] v;
        input [15:0]        lim;
        reg signed [31:0]   l;
        begin
            l = $signed({16'h0000, lim});
            if (v > l) begin
                clamp_sym = l;
            end else if (v < -l) begin
                clamp_sym = -l;
            end else begin
                clamp_sym = v;
            end
        end
    endfunction

    assign fb_w        = {{16{feedback[15]}}, feedback};
    assign pid_mode_on = (mode_q >= `RMODE_PID1) && (mode_q <= `RMODE_CMD2);
    assign pid_on      = pid_mode_on && !pid_disable_input;
    assign trim_mode   = (mode_q == `RMODE_CMD1) || (mode_q == `RMODE_CMD2);
    assign det_lvl[0]  = lowlvl_q;
    assign det_lvl[1]  = highlvl_q;
    assign det_time[0] = lowtime_q;
    assign det_time[1] = hightime_q;

    // register writes
    always @(posedge clk) begin
        if (reset) begin
            mode_q     <= `RST_MODE;
            pgain_q    <= `RST_PGAIN;
            itime_q    <= `RST_ITIME;
            ilim_q     <= `RST_ILIM;
            dtime_q    <= `RST_DTIME;
            olim_q     <= `RST_OLIM;
            bias_q     <= `RST_BIAS;
            ftime_q    <= `RST_FTIME;
            pol_q      <= 1'b0;
            ogain_q    <= `RST_OGAIN;
            rev_q      <= 1'b0;
            supv_q     <= `RST_SUPV;
            lowlvl_q   <= `RST_LOWLVL;
            lowtime_q  <= `RST_LOWTIME;
            highlvl_q  <= `RST_HIGHLVL;
            hightime_q <= `RST_HIGHTIME;
            target_q   <= `RST_TARGET;
        end else if (wr_en) begin
            case (addr)
                `REG_MODE:     mode_q     <= wdata[2:0];
                `REG_PGAIN:    pgain_q    <= wdata;
                `REG_ITIME:    itime_q    <= wdata;
                `REG_ILIM:     ilim_q     <= wdata;
                `REG_DTIME:    dtime_q    <= wdata;
                `REG_OLIM:     olim_q     <= wdata;
                `REG_BIAS:     bias_q     <= wdata;
                `REG_FTIME:    ftime_q    <= wdata;
                `REG_POL:      pol_q      <= wdata[0];
                `REG_OGAIN:    ogain_q    <= wdata;
                `REG_REV:      rev_q      <= wdata[0];
                `REG_SUPV:     supv_q     <= wdata[2:0];
                `REG_LOWLVL:   lowlvl_q   <= wdata;
                `REG_LOWTIME:  lowtime_q  <= {8'h00, wdata[7:0]};
                `REG_HIGHLVL:  highlvl_q  <= wdata;
                `REG_HIGHTIME: hightime_q <= {8'h00, wdata[7:0]};
                `REG_TARGET:   target_q   <= wdata;
                default: begin
                end
            endcase
        end
    end

    // loop sample tick
    always @(posedge clk) begin
        if (reset) begin
            tick_cnt_q <= 16'h0000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == TICK_CYCLES - 16'h0001) begin
            tick_cnt_q <= 16'h0000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
            tick_q     <= 1'b0;
        end
    end

    // regulator arithmetic, evaluated for the next tick
    always @* begin
        err = $signed({{16{target_q[15]}}, target_q}) - fb_w;
        if (pol_q) begin
            err = -err;
        end
        if ((mode_q == `RMODE_PID2) || (mode_q == `RMODE_CMD2)) begin
            dsrc = pol_q ? fb_w : -fb_w;
        end else begin
            dsrc = err;
        end
        p_term = ($signed({16'h0000, pgain_q}) * err) / $signed(`GAIN_DIV);
        if (dtime_q == 16'h0000) begin
            d_term = 32'h00000000;
        end else begin
            d_term = $signed({16'h0000, dtime_q}) * (dsrc - dprev_q) * `TIME_UNIT_TICKS;
        end
        i_div  = (itime_q == 16'h0000) ? 32'h00000001 : $signed({16'h0000, itime_q}) * `TIME_UNIT_TICKS;
        i_next = iacc_q + err;
        i_quot = i_next / i_div;
        i_hold = (i_quot > $signed({16'h0000, ilim_q})) || (i_quot < -$signed({16'h0000, ilim_q}));
        sum    = p_term + iterm_q + d_term;
        lim_v  = clamp_sym(sum, olim_q);
        f_div  = $signed({16'h0000, ftime_q}) * `TIME_UNIT_TICKS;
        if (ftime_q == 16'h0000) begin
            f_next = lim_v <<< `FILT_SHIFT;
        end else begin
            f_next = fy_q + ((lim_v <<< `FILT_SHIFT) - fy_q) / f_div;
        end
        biased = (f_next >>> `FILT_SHIFT) + $signed({{16{bias_q[15]}}, bias_q});
        gained = (biased * $signed({16'h0000, ogain_q})) / $signed(`GAIN_DIV);
        if ((gained < 32'sh00000000) && !rev_q) begin
            pid_v     = 32'h00000000;
            negstop_v = 1'b1;
        end else begin
            pid_v     = gained;
            negstop_v = 1'b0;
        end
        if (pid_on && trim_mode) begin
            out_v = $signed({{16{freq_command[15]}}, freq_command}) + pid_q;
        end else if (pid_on) begin
            out_v = pid_q;
        end else begin
            out_v = $signed({{16{freq_command[15]}}, freq_command});
        end
        out_v = clamp_sym(out_v, `FULL_SCALE_16);
    end

    // regulator state, held clear every cycle while pid is off except dprev_q, which follows dsrc, else updated once per tick
    always @(posedge clk) begin
        if (reset) begin
            iacc_q    <= 32'h00000000;
            iterm_q   <= 32'h00000000;
            dprev_q   <= 32'h00000000;
            fy_q      <= 32'h00000000;
            pid_q     <= 32'h00000000;
            negstop_q <= 1'b0;
        end else if (!pid_on) begin
            iacc_q    <= 32'h00000000;
            iterm_q   <= 32'h00000000;
            dprev_q   <= dsrc;
            fy_q      <= 32'h00000000;
            pid_q     <= 32'h00000000;
            negstop_q <= 1'b0;
        end else if (tick_q) begin
            dprev_q   <= dsrc;
            fy_q      <= f_next;
            pid_q     <= pid_v;
            negstop_q <= negstop_v;
            if (itime_q == 16'h0000) begin
                iacc_q  <= 32'h00000000;
                iterm_q <= 32'h00000000;
            end else if (i_hold) begin
                iterm_q <= (i_quot < 32'sh00000000) ? -$signed({16'h0000, ilim_q}) : $signed({16'h0000, ilim_q});
            end else begin
                iacc_q  <= i_next;
                iterm_q <= i_quot;
            end
        end
    end

    // supervision window per mode
    always @* begin
        case (supv_q)
            `SUP_IND_D, `SUP_ALARM_D, `SUP_FAULT_D: begin
                sup_act = drive_running && pid_mode_on;
            end
            `SUP_IND_ANY: begin
                sup_act = pid_on;
            end
            default: begin
                sup_act = drive_running && pid_on;
            end
        endcase
    end

    // low (0) and high (1) qualification timers
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_det
            reg  [15:0] cnt_q;
            wire [31:0] thr;
            wire [15:0] lim;
            wire        viol;
            assign thr  = $signed({16'h0000, det_lvl[ch]}) * `LVL_SCALE;
            assign lim  = {8'h00, det_time[ch][7:0]} * `DET_UNIT_TICKS;
            assign viol = (ch == 0) ? (fb_w < $signed(thr)) : (fb_w > $signed(thr));
            always @(posedge clk) begin
                if (reset) begin
                    cnt_q <= 16'h0000;
                end else if (!sup_act || !viol) begin
                    cnt_q <= 16'h0000;
                end else if (tick_q && (cnt_q != `CNT_MAX)) begin
                    cnt_q <= cnt_q + 16'h0001;
                end
            end
            assign det[ch] = sup_act && viol && (cnt_q > lim);
        end
    endgenerate

    // indications, alarm, fault and drive outputs
    always @(posedge clk) begin
        if (reset) begin
            fb_low_out_q  <= 1'b0;
            fb_high_out_q <= 1'b0;
            alarm_out_q   <= 1'b0;
            fault_out_q   <= 1'b0;
            freq_out_q    <= 16'h0000;
            reverse_q     <= 1'b0;
            stop_q        <= 1'b0;
        end else begin
            case (supv_q)
                `SUP_IND, `SUP_IND_D, `SUP_IND_RUN, `SUP_IND_ANY: begin
                    fb_low_out_q  <= det[0];
                    fb_high_out_q <= det[1];
                    alarm_out_q   <= 1'b0;
                end
                `SUP_ALARM, `SUP_ALARM_D: begin
                    fb_low_out_q  <= det[0];
                    fb_high_out_q <= det[1];
                    alarm_out_q   <= |det;
                end
                default: begin
                    fb_low_out_q  <= 1'b0;
                    fb_high_out_q <= 1'b0;
                    alarm_out_q   <= 1'b0;
                end
            endcase
            // fault latches; a new detection beats a reset request
            if (((supv_q == `SUP_FAULT) || (supv_q == `SUP_FAULT_D)) && (|det)) begin
                fault_out_q <= 1'b1;
            end else if (fault_reset) begin
                fault_out_q <= 1'b0;
            end
            freq_out_q <= out_v[15:0];
            reverse_q  <= out_v < 32'sh00000000;
            stop_q     <= fault_out_q || (pid_on && negstop_q);
        end
    end

    // status word
    always @* begin
        status_v            = 8'h00;
        status_v[`ST_LOW]   = det[0];
        status_v[`ST_HIGH]  = det[1];
        status_v[`ST_ALARM] = alarm_out_q;
        status_v[`ST_FAULT] = fault_out_q;
        status_v[`ST_STOP]  = stop_q;
        status_v[`ST_REV]   = reverse_q;
        status_v[`ST_PIDON] = pid_on;
        status_v[`ST_ACT]   = sup_act;
    end

    // read data, valid only in the cycle after the strobe
    always @(posedge clk) begin
        if (reset || !rd_en) begin
            rdata_q <= 16'h0000;
        end else begin
            case (addr)
                `REG_MODE:     rdata_q <= {13'h0000, mode_q};
                `REG_PGAIN:    rdata_q <= pgain_q;
                `REG_ITIME:    rdata_q <= itime_q;
                `REG_ILIM:     rdata_q <= ilim_q;
                `REG_DTIME:    rdata_q <= dtime_q;
                `REG_OLIM:     rdata_q <= olim_q;
                `REG_BIAS:     rdata_q <= bias_q;
                `REG_FTIME:    rdata_q <= ftime_q;
                `REG_POL:      rdata_q <= {15'h0000, pol_q};
                `REG_OGAIN:    rdata_q <= ogain_q;
                `REG_REV:      rdata_q <= {15'h0000, rev_q};
                `REG_SUPV:     rdata_q <= {13'h0000, supv_q};
                `REG_LOWLVL:   rdata_q <= lowlvl_q;
                `REG_LOWTIME:  rdata_q <= lowtime_q;
                `REG_HIGHLVL:  rdata_q <= highlvl_q;
                `REG_HIGHTIME: rdata_q <= hightime_q;
                `REG_TARGET:   rdata_q <= target_q;
                `REG_STATUS:   rdata_q <= {8'h00, status_v};
                `REG_PIDOUT:   rdata_q <= pid_q[15:0];
                default:       rdata_q <= 16'h0000;
            endcase
        end
    end

endmodule

// file: verification/prfm_sva.sv
// port assertions for the pid regulator and feedback monitor
`timescale 1ns/1ps
module prfm_sva #(
    parameter [15:0] TICK_CYCLES = 16'h61A8
) (
    input wire        clk,
    input wire        reset,
    input wire [4:0]  addr,
    input wire [15:0] wdata,
    input wire        wr_en,
    input wire        rd_en,
    input wire [15:0] rdata_q,
    input wire [15:0] feedback,
    input wire [15:0] freq_command,
    input wire        drive_running,
    input wire        pid_disable_input,
    input wire        fault_reset,
    input wire [15:0] freq_out_q,
    input wire        reverse_q,
    input wire        stop_q,
    input wire        fb_low_out_q,
    input wire        fb_high_out_q,
    input wire        alarm_out_q,
    input wire        fault_out_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_out_range: assert property ($signed(freq_out_q) <= 16'sh03E8 && $signed(freq_out_q) >= -16'sh03E8)
        else $error("output frequency out of range");
    a_alarm_ind: assert property (alarm_out_q |-> fb_low_out_q || fb_high_out_q)
        else $error("alarm without low or high indication");
    a_fault_stop: assert property (fault_out_q |-> ##[0:1] stop_q)
        else $error("fault without stop");
    a_fault_hold: assert property (fault_out_q && !fault_reset |=> fault_out_q)
        else $error("fault dropped without fault reset");
    a_rev_sign: assert property ($signed(freq_out_q) < 0 |-> ##[0:1] reverse_q)
        else $error("negative output without reverse");
    a_alarm_fault: assert property (!(alarm_out_q && fault_out_q))
        else $error("alarm and fault together");
    a_fault_quiet: assert property ($rose(fault_out_q) |-> !fb_low_out_q && !fb_high_out_q)
        else $error("fault raised with indication");
    a_reset_clear: assert property ($past(reset) |-> freq_out_q == 16'h0000 && !stop_q && !fault_out_q && !alarm_out_q)
        else $error("outputs not clear after reset");

    cover property ($rose(fault_out_q));
    cover property ($rose(alarm_out_q));
    cover property ($rose(reverse_q));
endmodule

bind prfm_regulator prfm_sva #(.TICK_CYCLES(TICK_CYCLES)) prfm_sva_i (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
    .feedback(feedback), .freq_command(freq_command), .drive_running(drive_running),
    .pid_disable_input(pid_disable_input), .fault_reset(fault_reset), .freq_out_q(freq_out_q),
    .reverse_q(reverse_q), .stop_q(stop_q), .fb_low_out_q(fb_low_out_q), .fb_high_out_q(fb_high_out_q),
    .alarm_out_q(alarm_out_q), .fault_out_q(fault_out_q));

// file: verification/prfm_plant.sv
// far-side source of feedback, frequency command and run levels
`timescale 1ns/1ps
module prfm_plant (
    input  wire        clk,
    input  wire [15:0] fb_set,
    input  wire [15:0] cmd_set,
    input  wire        run_set,
    input  wire        dis_set,
    output reg  [15:0] feedback = 16'h0000,
    output reg  [15:0] freq_command = 16'h0000,
    output reg         drive_running = 1'b0,
    output reg         pid_disable_input = 1'b0
);
    // levels move only just after an edge, like sampled sensors
    always @(posedge clk) begin
        feedback          <= fb_set;
        freq_command      <= cmd_set;
        drive_running     <= run_set;
        pid_disable_input <= dis_set;
    end
endmodule

// file: verification/prfm_regulator_test.sv
// self-checking bench for the regulator
`timescale 1ns/1ps
`include "prfm_consts.vh"
module prfm_regulator_test;
    reg         clk = 1'b0;
    reg         reset = 1'b1;
    reg  [4:0]  addr = 5'h00;
    reg  [15:0] wdata = 16'h0000;
    reg         wr_en = 1'b0;
    reg         rd_en = 1'b0;
    reg         fault_reset = 1'b0;
    reg  [15:0] fb_set = 16'h0000;
    reg  [15:0] cmd_set = 16'h0000;
    reg         run_set = 1'b1;
    reg         dis_set = 1'b0;
    reg         rd_d = 1'b0;
    reg         smp = 1'b0;
    reg  [23:0] note;
    reg  [23:0] note_q [$];
    wire [15:0] rdata_q, feedback, freq_command, freq_out_q;
    wire        drive_running, pid_disable_input, reverse_q, stop_q;
    wire        fb_low_out_q, fb_high_out_q, alarm_out_q, fault_out_q;
    wire [21:0] stat = {freq_out_q, reverse_q, stop_q, fb_low_out_q, fb_high_out_q, alarm_out_q, fault_out_q};
    integer     fail_count = 0;
    integer     checked = 0;
    integer     cyc = 0;
    integer     i;
    integer     rnd;
    integer     seed = 32'h3F676D57;
    localparam logic [15:0] DEF [0:16] = '{16'h0000, 16'h0064, 16'h0064, 16'h03E8, 16'h0000, 16'h03E8,
        16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h000A, 16'h0064,
        16'h000A, 16'h0000};
    // supervision mode, running, disable input, expected {low, high, alarm, fault}
    localparam logic [8:0] SUP [0:9] = '{9'h024, 9'h066, 9'h0A1, 9'h1A4, 9'h1C4, 9'h000, 9'h0F4,
        9'h136, 9'h171, 9'h030};

    always #20 clk = ~clk;

    prfm_plant prfm_plant_i (.clk(clk), .fb_set(fb_set), .cmd_set(cmd_set), .run_set(run_set), .dis_set(dis_set),
        .feedback(feedback), .freq_command(freq_command), .drive_running(drive_running),
        .pid_disable_input(pid_disable_input));

    prfm_regulator #(.TICK_CYCLES(16'h0004)) prfm_regulator_i (.clk(clk), .reset(reset), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .feedback(feedback),
        .freq_command(freq_command), .drive_running(drive_running), .pid_disable_input(pid_disable_input),
        .fault_reset(fault_reset), .freq_out_q(freq_out_q), .reverse_q(reverse_q), .stop_q(stop_q),
        .fb_low_out_q(fb_low_out_q), .fb_high_out_q(fb_high_out_q), .alarm_out_q(alarm_out_q),
        .fault_out_q(fault_out_q));

    task check(input string what, input logic [21:0] got, input logic [21:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task results;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // results are taken off the queue in the order they were noted
    always @(posedge clk) begin
        rd_d <= rd_en;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            results;
        end else if ((rd_d || smp) && note_q.size() > 0) begin
            note = note_q.pop_front();
            case (note[23:22])
                2'h0: check("rdata", {6'h00, rdata_q}, {6'h00, note[15:0]});
                2'h1: check("status", stat, note[21:0]);
                default: check("flags", {18'h00000, stat[3:0]}, {18'h00000, note[3:0]});
            endcase
        end
    end

    task wr(input [4:0] a, input integer d);
        @(posedge clk);
        addr <= a;
        wdata <= d[15:0];
        wr_en <= 1'b1;
        rd_en <= 1'b0;
    endtask

    task rd(input [4:0] a, input [15:0] e);
        note_q.push_back({8'h00, e});
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        wr_en <= 1'b0;
    endtask

    task idle;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask

    task sample(input [1:0] k, input [21:0] e);
        note_q.push_back({k, e});
        @(posedge clk);
        smp <= 1'b1;
        @(posedge clk);
        smp <= 1'b0;
    endtask

    task ticks(input integer n);
        repeat (n * 4) @(posedge clk);
    endtask

    task reg_case(input integer m, t, f, og, bias, olim, pol, rev, cmd, it, ilim);
        integer p;
        reg     stp;
        wr(`REG_MODE, m);
        wr(`REG_TARGET, t);
        wr(`REG_OGAIN, og);
        wr(`REG_BIAS, bias);
        wr(`REG_OLIM, olim);
        wr(`REG_POL, pol);
        wr(`REG_REV, rev);
        wr(`REG_ITIME, it);
        wr(`REG_ILIM, ilim);
        idle;
        fb_set <= f[15:0];
        cmd_set <= cmd[15:0];
        ticks(80);
        p = pol ? f - t : t - f;
        if (it != 0)
            p = p + (p > 0 ? ilim : -ilim);
        if (p > olim)
            p = olim;
        if (p < -olim)
            p = -olim;
        p = (p + bias) * og / 100;
        stp = (p < 0) && (rev == 0);
        if (stp)
            p = 0;
        if (m > 2)
            p = p + cmd;
        sample(2'h1, {p[15:0], p < 0, stp, 4'h0});
    endtask

    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        for (i = 0; i < 17; i = i + 1)
            rd(i[4:0], DEF[i]);
        rd(5'h1F, 16'h0000);
        rnd = $random(seed) % 1000;
        wr(`REG_BIAS, rnd);
        rd(`REG_BIAS, rnd[15:0]);
        idle;
        reg_case(1, 300, 0, 100, 0, 1000, 0, 0, 0, 0, 1000);
        reg_case(1, 300, 0, 100, 0, 1000, 1, 0, 0, 0, 1000);
        reg_case(1, 300, 0, 100, 0, 1000, 1, 1, 0, 0, 1000);
        rnd = $random(seed) % 100;
        reg_case(3, 300, 0, 200, 100, 1000, 0, 1, rnd, 0, 1000);
        reg_case(4, 100, 300, 100, 0, 100, 0, 1, -50, 0, 1000);
        reg_case(2, 300, 100, 100, 0, 1000, 0, 0, 0, 1, 100);
        wr(`REG_FTIME, 1);
        reg_case(1, 200, 0, 100, 0, 1000, 0, 0, 0, 0, 1000);
        wr(`REG_MODE, 1);
        wr(`REG_SUPV, 0);
        wr(`REG_LOWLVL, 10);
        wr(`REG_LOWTIME, 1);
        idle;
        fb_set <= 16'h0032;
        ticks(90);
        sample(2'h2, 22'h0);
        fb_set <= 16'h00C8;
        ticks(3);
        fb_set <= 16'h0032;
        ticks(90);
        sample(2'h2, 22'h0);
        ticks(15);
        sample(2'h2, 22'h8);
        fb_set <= 16'h0000;
        wr(`REG_LOWLVL, 0);
        wr(`REG_HIGHLVL, 50);
        wr(`REG_HIGHTIME, 0);
        for (i = 0; i < 10; i = i + 1) begin
            wr(`REG_SUPV, SUP[i][8:6]);
            idle;
            run_set <= SUP[i][5];
            dis_set <= SUP[i][4];
            fb_set <= 16'h02BC;
            ticks(6);
            sample(2'h2, {18'h00000, SUP[i][3:0]});
            fb_set <= 16'h0000;
            ticks(3);
            fault_reset <= 1'b1;
            @(posedge clk);
            fault_reset <= 1'b0;
            ticks(2);
            sample(2'h2, 22'h0);
        end
        ticks(2);
        results;
    end
endmodule
